// ===== design/dmcpg_pkg.sv
// package: constants and types for the dual mode clock phase generator
package dmcpg_pkg;
    // clock select pin levels
    localparam logic MODE_DOUBLE_RATE = 1'b0;
    localparam logic MODE_SINGLE_RATE = 1'b1;
    // reset hold figures, in rising edges of the selected mode's input clock
    localparam int   HOLD_CYC_SINGLE  = 32;
    localparam int   HOLD_CYC_DOUBLE  = 64;
    // pll lock time in microseconds and system clock rate
    localparam int   PLL_LOCK_US      = 500;
    localparam int   CLK_SYS_MHZ      = 50;
    localparam int   PLL_LOCK_CYC     = PLL_LOCK_US * CLK_SYS_MHZ;
    localparam int   CNT_W            = 16;
    // cycle phase encodings
    typedef enum logic [1:0] {
        DMCPG_PH_IDLE,
        DMCPG_PH_A,
        DMCPG_PH_B
    } dmcpg_phase_t;
endpackage

// ===== design/dmcpg_edge_if.sv
// interface: sampled edge events from the edge detector to the core
`timescale 1ns/1ps
interface dmcpg_edge_if;
    logic rise;
    logic fall;
    logic level;
    logic phase_n;
    modport src (output rise, output fall, output level, output phase_n);
    modport dst (input rise, input fall, input level, input phase_n);
endinterface // dmcpg_edge_if

// ===== design/dmcpg_edge_det.sv
// edge detector: synchronises a clock pin and its phase input
`timescale 1ns/1ps
module dmcpg_edge_det (
    // system
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    input  wire logic ce_i,
    // pins
    input  wire logic clk_pin_i,
    input  wire logic phase_pin_i,
    // events
    dmcpg_edge_if.src ev
);
    logic [2:0] clk_q;
    logic [2:0] ph_q;

    // two stages before use; third stage is the edge history
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            clk_q <= 3'h0;
            ph_q  <= 3'h7;
        end else if (ce_i) begin
            clk_q <= {clk_q[1:0], clk_pin_i};
            ph_q  <= {ph_q[1:0], phase_pin_i};
        end
    end

    assign ev.rise    = ce_i & clk_q[1] & ~clk_q[2];
    assign ev.fall    = ce_i & ~clk_q[1] & clk_q[2];
    assign ev.level   = clk_q[1];
    // phase taken from the history stage, one sample older than the clock level, so it is the value just before the edge
    assign ev.phase_n = ph_q[2];
endmodule // dmcpg_edge_det

// ===== design/dmcpg_core.sv
// top: internal clock and cycle a/b phase generation, two clock modes
// How it works
// [RL1] select low: timing from double-rate clock plus phase select
// [RL2] double-rate mode: internal clock is double-rate clock halved by phase
// [RL3] double-rate mode: operations use both double-rate and derived clock
// [RL4] cycle a ends at double-rate rising edge with phase select high
// [RL5] cycle b ends at double-rate falling edge with phase select low
// [RL6] host holds cycle a data stable at cycle a end
// [RL7] host holds cycle b data stable at cycle b end
// [RL8] select high: single-rate clock only, others ignored
// [RL9] single-rate mode: clock doubled then halved for internal clock
// [RL10] host holds reset through pll lock plus 32 or 64 cycles
// [RL11] single-rate mode: inputs sampled at twice single-rate frequency
// [RL12] host toggles phase select once per double-rate cycle
`timescale 1ns/1ps
module dmcpg_core #(
    parameter int DATA_W       = 72,
    parameter int LOCK_CYC     = dmcpg_pkg::PLL_LOCK_CYC
) (
    // system
    input  wire logic              clk_sys_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    // clock pins
    input  wire logic              clk_mode_i,
    input  wire logic              double_rate_clock_in_i,
    input  wire logic              phase_select_n_i,
    input  wire logic              single_rate_clock_in_i,
    // data pins
    input  wire logic [DATA_W-1:0] data_i,
    // outputs
    output logic                   int_clk_o,
    output logic                   fast_tick_o,
    output logic                   cycle_a_end_o,
    output logic                   cycle_b_end_o,
    output logic [DATA_W-1:0]      data_a_o,
    output logic [DATA_W-1:0]      data_b_o,
    output logic                   locked_o,
    output logic                   ready_o
);
    import dmcpg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    dmcpg_edge_if dbl_ev ();
    dmcpg_edge_if sgl_ev ();

    dmcpg_edge_det u_dbl (
        .clk_sys_i   (clk_sys_i),
        .srst_i      (srst_i),
        .ce_i        (ce_i),
        .clk_pin_i   (double_rate_clock_in_i),
        .phase_pin_i (phase_select_n_i),
        .ev          (dbl_ev.src)
    );
    dmcpg_edge_det u_sgl (
        .clk_sys_i   (clk_sys_i),
        .srst_i      (srst_i),
        .ce_i        (ce_i),
        .clk_pin_i   (single_rate_clock_in_i),
        .phase_pin_i (1'b1),
        .ev          (sgl_ev.src)
    );

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers for the mode pin and the data bus
    logic [1:0]        mode_q;
    logic [DATA_W-1:0] data_s1_q;
    logic [DATA_W-1:0] data_s2_q;
    logic              mode_sgl;

    // mode pin: two stages, read only from the second
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mode_q <= 2'h0;
        end else if (ce_i) begin
            mode_q <= {mode_q[0], clk_mode_i};
        end
    end

    // data keeps the same delay as the clock pin path
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            data_s1_q <= '0;
            data_s2_q <= '0;
        end else if (ce_i) begin
            data_s1_q <= data_i;
            data_s2_q <= data_s1_q;
        end
    end

    assign mode_sgl = mode_q[1];

    ////////////////////////////////////////////////////////////////////
    // edge history holds reset values for three samples; a pin already
    // high at release would look like a rise, so events wait for it
    logic [2:0] fill_q;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fill_q <= 3'h0;
        end else if (ce_i) begin
            fill_q <= {fill_q[1:0], 1'b1};
        end
    end

    wire warm     = fill_q[2];
    wire dbl_rise = warm & dbl_ev.rise;
    wire dbl_fall = warm & dbl_ev.fall;
    wire sgl_rise = warm & sgl_ev.rise;
    wire sgl_fall = warm & sgl_ev.fall;

    ////////////////////////////////////////////////////////////////////
    // [RL1] double-rate source select
    wire dbl_mode = (mode_sgl == MODE_DOUBLE_RATE);
    // [RL8] single-rate mode ignores double-rate pins
    wire a_end_dbl = dbl_mode & dbl_rise & dbl_ev.phase_n;
    wire b_end_dbl = dbl_mode & dbl_fall & ~dbl_ev.phase_n;
    // [RL9] pll doubling modelled as both edges of the single-rate clock
    wire fast_sgl  = ~dbl_mode & (sgl_rise | sgl_fall);
    wire a_end_sgl = ~dbl_mode & sgl_rise;
    wire b_end_sgl = ~dbl_mode & sgl_fall;

    // [RL4] cycle a end
    wire a_end = a_end_dbl | a_end_sgl;
    // [RL5] cycle b end
    wire b_end = b_end_dbl | b_end_sgl;
    // [RL3] fast tick is the double-rate clock in double-rate mode
    // [RL11] single-rate mode samples at the doubled rate
    wire fast  = (dbl_mode & (dbl_rise | dbl_fall)) | fast_sgl;

    ////////////////////////////////////////////////////////////////////
    logic              int_clk_q;
    logic              a_q;
    logic              b_q;
    logic              fast_q;
    logic [DATA_W-1:0] da_q;
    logic [DATA_W-1:0] db_q;

    // [RL2] halving aligned by phase: high during cycle b
    wire              int_clk_d = a_end | (int_clk_q & ~b_end);
    // [RL6] cycle a data captured at its end
    wire [DATA_W-1:0] da_d      = a_end ? data_s2_q : da_q;
    // [RL7] cycle b data captured at its end
    wire [DATA_W-1:0] db_d      = b_end ? data_s2_q : db_q;

    // end and tick pulses last one system cycle
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            a_q    <= 1'b0;
            b_q    <= 1'b0;
            fast_q <= 1'b0;
        end else if (ce_i) begin
            a_q    <= a_end;
            b_q    <= b_end;
            fast_q <= fast;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            int_clk_q <= 1'b0;
        end else if (ce_i) begin
            int_clk_q <= int_clk_d;
        end
    end

    // captured words hold until the next matching end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            da_q <= '0;
            db_q <= '0;
        end else if (ce_i) begin
            da_q <= da_d;
            db_q <= db_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lock timer is coarse: counted on the system clock, not the pll
    // limitation: LOCK_CYC must fit in CNT_W bits or the compare value truncates and lock comes early
    logic [CNT_W-1:0] lock_q;
    logic [CNT_W-1:0] extra_q;
    logic             locked_q;
    logic             ready_q;

    wire  [CNT_W-1:0] extra_need = dbl_mode ? CNT_W'(HOLD_CYC_DOUBLE)
                                            : CNT_W'(HOLD_CYC_SINGLE);
    wire              clk_tick   = dbl_mode ? dbl_rise : sgl_rise;
    wire              lock_run   = ~locked_q;
    wire              lock_done  = (lock_q >= CNT_W'(LOCK_CYC - 1));
    // [RL10] extra cycles counted only once the pll timer is done
    wire              extra_run  = locked_q & ~ready_q & clk_tick;
    wire              extra_done = (extra_q >= extra_need - CNT_W'(1));

    wire  [CNT_W-1:0] lock_d   = lock_run ? lock_q + CNT_W'(1) : lock_q;
    wire              locked_d = lock_run ? lock_done : locked_q;
    wire  [CNT_W-1:0] extra_d  = extra_run ? extra_q + CNT_W'(1) : extra_q;
    wire              ready_d  = extra_run ? extra_done : ready_q;

    // pll lock timer
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            lock_q   <= '0;
            locked_q <= 1'b0;
        end else if (ce_i) begin
            lock_q   <= lock_d;
            locked_q <= locked_d;
        end
    end

    // [RL10] readiness after lock plus extra cycles
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            extra_q <= '0;
            ready_q <= 1'b0;
        end else if (ce_i) begin
            extra_q <= extra_d;
            ready_q <= ready_d;
        end
    end

    assign int_clk_o     = int_clk_q;
    assign fast_tick_o   = fast_q;
    assign cycle_a_end_o = a_q;
    assign cycle_b_end_o = b_q;
    assign data_a_o      = da_q;
    assign data_b_o      = db_q;
    assign locked_o      = locked_q;
    assign ready_o       = ready_q;
endmodule // dmcpg_core

// ===== testbench/dmcpg_core_assertions.sv
// checker: output timing of the phase generator
`timescale 1ns/1ps
module dmcpg_core_assertions #(
    parameter int DATA_W = 72
) (
    // system
    input wire logic              clk_sys_i,
    input wire logic              srst_i,
    // outputs
    input wire logic              int_clk_o,
    input wire logic              cycle_a_end_o,
    input wire logic              cycle_b_end_o,
    input wire logic [DATA_W-1:0] data_a_o,
    input wire logic [DATA_W-1:0] data_b_o,
    input wire logic              locked_o,
    input wire logic              ready_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    property p_excl; !(cycle_a_end_o && cycle_b_end_o); endproperty
    a_excl: assert property (p_excl) else $error("a b overlap");
    property p_aclk; cycle_a_end_o |-> int_clk_o; endproperty
    a_aclk: assert property (p_aclk) else $error("clk low at a");
    property p_bclk; cycle_b_end_o |-> !int_clk_o; endproperty
    a_bclk: assert property (p_bclk) else $error("clk high at b");
    // derived clock moves only at a cycle end
    property p_csrc; $changed(int_clk_o) |-> cycle_a_end_o || cycle_b_end_o;
    endproperty
    a_csrc: assert property (p_csrc) else $error("stray clk edge");
    property p_da; $changed(data_a_o) |-> cycle_a_end_o; endproperty
    a_da: assert property (p_da) else $error("data a moved");
    property p_db; $changed(data_b_o) |-> cycle_b_end_o; endproperty
    a_db: assert property (p_db) else $error("data b moved");
    property p_rdy; ready_o |-> locked_o; endproperty
    a_rdy: assert property (p_rdy) else $error("ready unlocked");
    property p_lck; locked_o |=> locked_o; endproperty
    a_lck: assert property (p_lck) else $error("lock lost");
endmodule // dmcpg_core_assertions
bind dmcpg_core dmcpg_core_assertions #(.DATA_W(DATA_W)) u_chk (.*);

// ===== testbench/dmcpg_host_model.sv
// partner: host driving clock, phase and data pins
`timescale 1ns/1ps
module dmcpg_host_model #(
    parameter int H = 10
) (
    input  wire logic   clk_sys_i,
    // pins, and the data seen at the last edges
    output logic        dr_o,
    output logic        ph_n_o,
    output logic        sr_o,
    output logic [71:0] dat_o,
    output logic [71:0] rise_o,
    output logic [71:0] fall_o
);
    int cnt = 0;
    initial begin
        {dr_o, sr_o, ph_n_o} = 3'h1;
        {dat_o, rise_o, fall_o} = '0;
    end
    always @(posedge clk_sys_i) begin
        #1;
        cnt = (cnt + 1) % (2 * H);
        // single-rate pin lags two cycles so a leak shows in counts
        if (cnt == 0 || cnt == H)
            dr_o = (cnt == 0);
        if (cnt == 2 || cnt == H + 2)
            sr_o = (cnt == 2);
        if (cnt == 0)
            rise_o = dat_o;
        if (cnt == H)
            fall_o = dat_o;
        // data moves mid-level, clear of edges
        if (cnt % H == H / 2)
            dat_o = dat_o + 72'h1_0000_0001;
        // one phase toggle per double-rate cycle
        if (cnt == 3 * H / 2)
            ph_n_o = ~ph_n_o;
    end
endmodule // dmcpg_host_model

// ===== testbench/dmcpg_core_tb.sv
// testbench: boot, capture and mode checks
`timescale 1ns/1ps
module dmcpg_core_tb;
    localparam int H = 10;
    logic        clk_sys_i = 0;
    logic        srst_i = 1;
    logic        mode = 0;
    logic        ce = 1;
    logic        dr, ph_n, sr, clk, tick, a_end, b_end, lck, rdy;
    logic [71:0] dat, da, db, rise_d, fall_d;
    int          error_cnt = 0;
    int          n_checks = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    dmcpg_host_model #(.H(H)) u_dmcpg_host_model (.clk_sys_i(clk_sys_i),
        .dr_o(dr), .ph_n_o(ph_n), .sr_o(sr), .dat_o(dat), .rise_o(rise_d),
        .fall_o(fall_d));
    dmcpg_core #(.LOCK_CYC(20)) u_dmcpg_core (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .ce_i(ce), .clk_mode_i(mode),
        .double_rate_clock_in_i(dr), .phase_select_n_i(ph_n),
        .single_rate_clock_in_i(sr), .data_i(dat), .int_clk_o(clk),
        .fast_tick_o(tick), .cycle_a_end_o(a_end), .cycle_b_end_o(b_end),
        .data_a_o(da), .data_b_o(db), .locked_o(lck), .ready_o(rdy));
    task summarize;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // bounded wait: a used-up bound ends the run
    task step(inout int k, input int lim);
        @(posedge clk_sys_i);
        #1;
        k++;
        if (k > lim) begin
            chk(1'b0, "timeout");
            summarize();
        end
    endtask
    task t_boot(input logic m, input int n);
        int k;
        mode = m;
        srst_i = 1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk({clk, a_end, b_end, lck, rdy} === 5'h0, "reset");
        srst_i = 0;
        k = 0;
        while (lck !== 1'b1)
            step(k, 40);
        chk(k >= 18 && k <= 26 && rdy === 1'b0, "lock");
        k = 0;
        while (rdy !== 1'b1)
            step(k, 2 * H * (n + 2));
        chk(k > 2 * H * (n - 1) && k <= 2 * H * (n + 1) + 8, "rdy");
    endtask
    task t_cap;
        int k;
        k = 0;
        while (a_end !== 1'b1)
            step(k, 4 * H);
        chk(da === rise_d && clk === 1'b1, "cycle a");
        k = 0;
        while (b_end !== 1'b1)
            step(k, 4 * H);
        chk(db === fall_d && clk === 1'b0, "cycle b");
    endtask
    // counts over eight pin periods; the unused pins keep running
    task t_cnt(input logic m, input int na, input int nb);
        int a, b, t;
        {a, b, t} = '0;
        mode = m;
        repeat (4 * H) @(posedge clk_sys_i);
        repeat (16 * H) begin
            @(posedge clk_sys_i);
            #1;
            a += a_end;
            b += b_end;
            t += tick;
        end
        chk(a == na && b == nb && t == 16, "edge counts");
    endtask
    // clock enable low must freeze every output
    task t_hold;
        logic [149:0] snap;
        int           k;
        snap = {clk, tick, a_end, b_end, lck, rdy, da, db};
        ce = 1'b0;
        k = 0;
        repeat (2 * H) begin
            @(posedge clk_sys_i);
            #1;
            k += (snap !== {clk, tick, a_end, b_end, lck, rdy, da, db});
        end
        ce = 1'b1;
        chk(k == 0, "freeze");
    endtask
    initial begin
        t_boot(1'b1, 32);
        t_cap();
        t_cnt(1'b1, 8, 8);
        t_cnt(1'b0, 4, 4);
        t_cap();
        t_hold();
        t_boot(1'b0, 64);
        summarize();
    end
endmodule // dmcpg_core_tb
